// file: shared/rfcfg_pkg.sv
package rfcfg_pkg;

  localparam int NREG = 6;

  // Slot numbers inside the bank
  localparam int SLOT_THR  = 0;
  localparam int SLOT_CHAN = 1;
  localparam int SLOT_VCO  = 2;
  localparam int SLOT_PLL  = 3;
  localparam int SLOT_TXP  = 4;
  localparam int SLOT_BATT = 5;

  // Register indices; byte address is four times the index
  localparam logic [29:0] IDX_CCA_THR = 30'h0000003F;
  localparam logic [29:0] IDX_CHAN    = 30'h00000200;
  localparam logic [29:0] IDX_VCO     = 30'h00000201;
  localparam logic [29:0] IDX_PLL     = 30'h00000202;
  localparam logic [29:0] IDX_TXP     = 30'h00000203;
  localparam logic [29:0] IDX_BATT    = 30'h00000205;

  localparam logic [29:0] REG_IDX [NREG] = '{
    IDX_CCA_THR, IDX_CHAN, IDX_VCO, IDX_PLL, IDX_TXP, IDX_BATT};

  // Writable bits; reserved bits are not stored and read as zero
  localparam logic [7:0] REG_MASK [NREG] = '{
    8'hFF, 8'hFF, 8'hFF, 8'h80, 8'hF8, 8'hF0};

  localparam logic [7:0] REG_RST = 8'h00;

  // Field positions
  localparam int CHAN_LSB   = 4;
  localparam int RFTUNE_LSB = 0;
  localparam int PLL_BIT    = 7;
  localparam int COARSE_LSB = 6;
  localparam int FINE_LSB   = 3;
  localparam int BATT_LSB   = 4;

  localparam logic [4:0]  CHAN_BASE_NUM  = 5'h0B;
  localparam logic [11:0] FREQ_BASE_MHZ  = 12'h965;
  localparam logic [11:0] FREQ_STEP_MHZ  = 12'h005;
  localparam logic [8:0]  COARSE_STEP_TD = 9'h064;

  // Fine attenuation in tenths of a dB, per code
  localparam logic [8:0] FINE_TD [8] = '{
    9'h000, 9'h005, 9'h00C, 9'h013, 9'h01C, 9'h025, 9'h031, 9'h03F};

  // Battery threshold in tenths of a volt, codes 0 to 15
  localparam logic [5:0] BATT_DV [16] = '{
    6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h19,
    6'h1A, 6'h1B, 6'h1C, 6'h1F, 6'h20, 6'h21, 6'h23, 6'h00};
  localparam logic [3:0] BATT_MIN_CODE = 4'h7;
  localparam logic [3:0] BATT_MAX_CODE = 4'hE;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  typedef struct packed {
    logic [7:0]  energy_busy_threshold;
    logic [3:0]  channel_code;
    logic [4:0]  channel_num;
    logic [11:0] freq_mhz;
    logic [3:0]  rf_tune_field;
    logic [7:0]  vco_tune_field;
    logic        synth_pll_on;
    logic [1:0]  tx_coarse_atten;
    logic [2:0]  tx_fine_atten;
    logic [8:0]  atten_tenth_db;
    logic [3:0]  low_supply_threshold;
    logic [5:0]  low_supply_decivolt;
    logic        low_supply_valid;
  } rfcfg_radio_t;

endpackage

// file: src/rfcfg_sync.sv
module rfcfg_sync #(
  parameter int W = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= '0;
      q    <= '0;
    end else begin
      s1_r <= d;
      q    <= s1_r;
    end
  end
endmodule // rfcfg_sync

// file: src/rfcfg_reg.sv
module rfcfg_reg
  import rfcfg_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hFF,
  parameter logic [7:0] RST  = 8'h00
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);
  logic [7:0] q_nxt;

  always_comb begin
    q_nxt = q;
    if (wr_en) begin
      q_nxt = wdata & MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= RST;
    end else begin
      q <= q_nxt;
    end
  end
endmodule // rfcfg_reg

// file: src/rfcfg_regbank.sv
// Functional notes
// R1: Channel busy when measured energy exceeds the 8-bit threshold.
// R2: Threshold resets to 0x00; software should program 0x60.
// R3: Channel code bits 7-4 select channel 11 to 26, 2405 to 2480 MHz.
// R4: RF tune field in bits 3-0, resets 0x0, recommended 0x3.
// R5: VCO tune register, 8 bits, resets 0x0, recommended 0x2.
// R6: Bit 7 enables the synthesizer PLL, resets disabled.
// R7: Software enables the PLL before any receive or transmit.
// R8: Coarse attenuation bits 7-6: 0, -10, -20, -30 dB.
// R9: Fine attenuation bits 5-3: 0 to -6.3 dB in eight steps.
// R10: Software writes zero to all reserved bits.
// R11: Battery threshold in bits 7-4, resets zero, low bits reserved.
// R12: Battery codes 0111 to 1110 map to 2.5 V to 3.5 V.
// R13: Reads return last written value, or reset value.
module rfcfg_regbank (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic [7:0]             energy_level,
  output logic                        cca_busy,
  output rfcfg_pkg::rfcfg_radio_t     radio
);
  import rfcfg_pkg::*;

  logic [7:0]         cfg [NREG];
  logic [NREG-1:0]    wr_en;
  logic [7:0]         energy_s;

  // Address phase capture
  logic               take;
  logic               hit;
  logic [2:0]         slot;
  logic               wr_pend_r, wr_pend_nxt;
  logic [2:0]         wr_slot_r, wr_slot_nxt;
  logic [31:0]        hrdata_r, hrdata_nxt;
  logic               fwd;
  logic [7:0]         rd_val;

  logic               cca_busy_r, cca_busy_nxt;
  rfcfg_radio_t       radio_r, radio_nxt;
  logic               thr_written_r, thr_written_nxt;

  rfcfg_sync #(
    .W (8)
  ) u_energy_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (energy_level),
    .q       (energy_s)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      rfcfg_reg #(
        .MASK (REG_MASK[gi]),
        .RST  (REG_RST) // R2
      ) u_reg (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (wr_en[gi]),
        .wdata   (hwdata[7:0]),
        .q       (cfg[gi])
      );
    end
  endgenerate

  // Address decode against the index table
  always_comb begin
    take = hsel && hready && (htrans == HTRANS_NONSEQ);
    hit  = 1'b0;
    slot = 3'h0;
    for (int i = 0; i < NREG; i++) begin
      if (haddr[31:2] == REG_IDX[i]) begin
        hit  = 1'b1;
        slot = 3'(i);
      end
    end
  end

  // Write commits at the end of its data phase
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      wr_en[i] = wr_pend_r && hready && (wr_slot_r == 3'(i)); // R13
    end
  end

  // Read mux with forwarding of a write still in its data phase
  always_comb begin
    fwd    = wr_pend_r && (wr_slot_r == slot);
    rd_val = cfg[slot];
    if (fwd) begin
      rd_val = hwdata[7:0] & REG_MASK[slot]; // R13
    end
  end

  always_comb begin
    wr_pend_nxt = wr_pend_r;
    wr_slot_nxt = wr_slot_r;
    hrdata_nxt  = hrdata_r;
    if (hready) begin
      wr_pend_nxt = take && hwrite && hit;
      wr_slot_nxt = slot;
      hrdata_nxt  = 32'h00000000;
      if (take && !hwrite && hit) begin
        hrdata_nxt = {24'h000000, rd_val}; // R13
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_slot_r <= 3'h0;
      hrdata_r  <= 32'h00000000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_slot_r <= wr_slot_nxt;
      hrdata_r  <= hrdata_nxt;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  assign hrdata = hrdata_r;

  // Radio settings, decoded one edge after the register changes
  always_comb begin
    logic [3:0] chan;
    logic [1:0] crs;
    logic [2:0] fin;
    logic [3:0] bat;
    chan = cfg[SLOT_CHAN][CHAN_LSB +: 4];
    crs  = cfg[SLOT_TXP][COARSE_LSB +: 2];
    fin  = cfg[SLOT_TXP][FINE_LSB +: 3];
    bat  = cfg[SLOT_BATT][BATT_LSB +: 4];
    radio_nxt = radio_r;
    radio_nxt.energy_busy_threshold = cfg[SLOT_THR];
    radio_nxt.channel_code  = chan; // R3
    radio_nxt.channel_num   = 5'(CHAN_BASE_NUM + {1'b0, chan}); // R3
    radio_nxt.freq_mhz      = 12'(FREQ_BASE_MHZ
                              + 12'(FREQ_STEP_MHZ * {8'h00, chan})); // R3
    radio_nxt.rf_tune_field  = cfg[SLOT_CHAN][RFTUNE_LSB +: 4]; // R4
    radio_nxt.vco_tune_field = cfg[SLOT_VCO]; // R5
    radio_nxt.synth_pll_on   = cfg[SLOT_PLL][PLL_BIT]; // R6
    radio_nxt.tx_coarse_atten = crs; // R8
    radio_nxt.tx_fine_atten   = fin; // R9
    radio_nxt.atten_tenth_db  = 9'(9'(COARSE_STEP_TD * {7'h00, crs})
                                + FINE_TD[fin]); // R8 R9
    radio_nxt.low_supply_threshold = bat; // R11
    radio_nxt.low_supply_decivolt  = BATT_DV[bat]; // R12
    radio_nxt.low_supply_valid     = (bat >= BATT_MIN_CODE)
                                     && (bat <= BATT_MAX_CODE); // R12
  end

  // Busy when energy strictly above the threshold
  always_comb begin
    cca_busy_nxt = energy_s > cfg[SLOT_THR]; // R1
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      radio_r    <= '0;
      cca_busy_r <= 1'b0;
    end else begin
      radio_r    <= radio_nxt;
      cca_busy_r <= cca_busy_nxt;
    end
  end

  assign radio    = radio_r;
  assign cca_busy = cca_busy_r;

  // Tracks whether the threshold has been written since reset
  always_comb begin
    thr_written_nxt = thr_written_r || wr_en[SLOT_THR];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thr_written_r <= 1'b0;
    end else begin
      thr_written_r <= thr_written_nxt;
    end
  end

  cca_busy_a: assert property ( // R1
    @(posedge hclk) disable iff (!hresetn)
    ($past(energy_s) > $past(cfg[SLOT_THR])) |-> cca_busy)
    else $error("busy flag missed energy above threshold");

  cca_idle_a: assert property ( // R1
    @(posedge hclk) disable iff (!hresetn)
    ($past(energy_s) <= $past(cfg[SLOT_THR])) |-> !cca_busy)
    else $error("busy flag set at or below threshold");

  thr_reset_a: assert property ( // R2
    @(posedge hclk) disable iff (!hresetn)
    !thr_written_r |-> (cfg[SLOT_THR] == 8'h00))
    else $error("threshold left reset value without a write");

  chan_freq_a: assert property ( // R3
    @(posedge hclk) disable iff (!hresetn)
    $changed(cfg[SLOT_CHAN]) |=>
      (radio.freq_mhz == 12'(12'h965 + 12'h005
        * {8'h00, $past(cfg[SLOT_CHAN][7:4])}))
      && (radio.channel_num == 5'(5'h0B
        + {1'b0, $past(cfg[SLOT_CHAN][7:4])})))
    else $error("channel or frequency decode wrong");

  rf_tune_a: assert property ( // R4
    @(posedge hclk) disable iff (!hresetn)
    ##1 radio.rf_tune_field == $past(cfg[SLOT_CHAN][3:0]))
    else $error("rf tune field not passed to radio");

  vco_tune_a: assert property ( // R5
    @(posedge hclk) disable iff (!hresetn)
    wr_en[SLOT_VCO] |-> ##2 radio.vco_tune_field == $past(hwdata[7:0], 2))
    else $error("vco tune write not seen by radio");

  pll_enable_a: assert property ( // R6
    @(posedge hclk) disable iff (!hresetn)
    (wr_en[SLOT_PLL] && hwdata[7]) |-> ##2 radio.synth_pll_on)
    else $error("pll enable write did not reach radio");

  coarse_atten_a: assert property ( // R8
    @(posedge hclk) disable iff (!hresetn)
    ($past(cfg[SLOT_TXP][7:6]) == 2'h3 && $past(cfg[SLOT_TXP][5:3]) == 3'h0)
      |-> radio.atten_tenth_db == 9'h12C)
    else $error("coarse code 3 is not 30 dB");

  fine_atten_a: assert property ( // R9
    @(posedge hclk) disable iff (!hresetn)
    ($past(cfg[SLOT_TXP][7:6]) == 2'h0 && $past(cfg[SLOT_TXP][5:3]) == 3'h7)
      |-> radio.atten_tenth_db == 9'h03F)
    else $error("fine code 7 is not 6.3 dB");

  batt_field_a: assert property ( // R11
    @(posedge hclk) disable iff (!hresetn)
    cfg[SLOT_BATT][3:0] == 4'h0 && cfg[SLOT_PLL][6:0] == 7'h00)
    else $error("reserved bits stored");

  batt_map_a: assert property ( // R12
    @(posedge hclk) disable iff (!hresetn)
    $past(cfg[SLOT_BATT][7:4]) == 4'hE |->
      radio.low_supply_valid && radio.low_supply_decivolt == 6'h23)
    else $error("battery code 1110 is not 3.5 V");

  batt_undef_a: assert property ( // R12
    @(posedge hclk) disable iff (!hresetn)
    $past(cfg[SLOT_BATT][7:4]) < 4'h7 |-> !radio.low_supply_valid)
    else $error("undefined battery code reported valid");

  write_back_a: assert property ( // R13
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && hready) |=>
      cfg[$past(wr_slot_r)] == ($past(hwdata[7:0])
        & REG_MASK[$past(wr_slot_r)]))
    else $error("write did not land in register");

  read_back_a: assert property ( // R13
    @(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && hit && !fwd) |=>
      hrdata == {24'h000000, $past(cfg[slot])} && hreadyout)
    else $error("read data differs from register");

endmodule // rfcfg_regbank

// file: test/tb_rfcfg_regbank.sv
module tb_rfcfg_regbank;
  timeunit 1ns;
  timeprecision 1ps;
  import rfcfg_pkg::*;

  typedef struct packed {
    logic [29:0] idx;
    logic [7:0]  wd;
    logic [7:0]  ex;
  } rfcfg_row_t;

  logic         hclk;
  logic         hresetn;
  logic         hsel;
  logic         hwrite;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  haddr;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  logic [7:0]   energy_level;
  logic         cca_busy;
  rfcfg_radio_t radio;
  logic [31:0]  v;
  int           n_errors;
  int           compares;

  // Fine steps in tenths of a dB, battery levels in tenths of a volt
  int ft [8]  = '{0, 5, 12, 19, 28, 37, 49, 63};
  int bv [16] = '{0, 0, 0, 0, 0, 0, 0, 25, 26, 27, 28, 31, 32, 33, 35, 0};

  // Reserved bits are always written as zero
  rfcfg_row_t rows [11] = '{
    '{IDX_CCA_THR, 8'h60, 8'h60}, '{IDX_CCA_THR, 8'hFF, 8'hFF},
    '{IDX_CHAN, 8'hF3, 8'hF3}, '{IDX_VCO, 8'h02, 8'h02},
    '{IDX_VCO, 8'hA5, 8'hA5}, '{IDX_PLL, 8'h80, 8'h80},
    '{IDX_PLL, 8'h00, 8'h00}, '{IDX_TXP, 8'hF8, 8'hF8},
    '{IDX_TXP, 8'h08, 8'h08}, '{IDX_BATT, 8'hF0, 8'hF0},
    '{IDX_BATT, 8'h70, 8'h70}};

  // Cca cases: threshold, energy, expected busy
  logic [7:0] ct [6] = '{8'h60, 8'h60, 8'h60, 8'h00, 8'h00, 8'hFF};
  logic [7:0] ce [6] = '{8'h60, 8'h61, 8'h5F, 8'h00, 8'h01, 8'hFF};
  logic       cb [6] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0};

  rfcfg_regbank i_rfcfg_regbank (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hready       (hreadyout),
    .hwdata       (hwdata),
    .hrdata       (hrdata),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .energy_level (energy_level),
    .cca_busy     (cca_busy),
    .radio        (radio)
  );

  initial hclk = 1'b0;
  always #10 hclk = ~hclk;

  task automatic end_sim();
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One single transfer; called just after a rising edge
  task automatic ahb(input logic [29:0] idx, input logic wr,
                     input logic [7:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
    // Value standing just before the closing edge
    rd = hrdata;
  endtask

  task automatic wr(input logic [29:0] idx, input logic [7:0] wd);
    logic [31:0] dummy;
    ahb(idx, 1'b1, wd, dummy);
  endtask

  task automatic settle();
    repeat (2) @(posedge hclk);
    #1;
  endtask

  initial begin
    #200_000;
    n_errors++;
    end_sim();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0;
    hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0; energy_level = 8'h00;
    repeat (8) @(posedge hclk);
    chk("radio_in_rst", {31'h0, radio === '0}, 32'h1);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < NREG; i++) begin
      ahb(REG_IDX[i], 1'b0, 8'h00, v);
      chk("reset_read", v, 32'h0);
    end
    for (int i = 0; i < 11; i++) begin
      wr(rows[i].idx, rows[i].wd);
      ahb(rows[i].idx, 1'b0, 8'h00, v);
      chk("row_read", v, {24'h0, rows[i].ex});
    end
    wr(IDX_PLL, 8'h80);
    wr(IDX_VCO, 8'h02);
    settle();
    chk("pll_on", radio.synth_pll_on, 32'h1);
    chk("vco", radio.vco_tune_field, 32'h2);
    for (int c = 0; c < 16; c++) begin
      wr(IDX_CHAN, {c[3:0], 4'h3});
      settle();
      chk("chan_code", radio.channel_code, c);
      chk("chan_num", radio.channel_num, 11 + c);
      chk("freq", radio.freq_mhz, 2405 + 5 * c);
      chk("rf_tune", radio.rf_tune_field, 32'h3);
    end
    for (int k = 0; k < 32; k++) begin
      wr(IDX_TXP, {k[4:0], 3'h0});
      settle();
      chk("coarse", radio.tx_coarse_atten, k / 8);
      chk("fine", radio.tx_fine_atten, k % 8);
      chk("atten", radio.atten_tenth_db, 100 * (k / 8) + ft[k % 8]);
    end
    for (int b = 0; b < 16; b++) begin
      wr(IDX_BATT, {b[3:0], 4'h0});
      settle();
      chk("batt", radio.low_supply_threshold, b);
      chk("batt_dv", radio.low_supply_decivolt, bv[b]);
      chk("batt_ok", radio.low_supply_valid, b >= 7 && b <= 14);
    end
    for (int i = 0; i < 6; i++) begin
      wr(IDX_CCA_THR, ct[i]);
      energy_level <= ce[i];
      repeat (6) @(posedge hclk);
      #1;
      chk("cca_busy", cca_busy, cb[i]);
      chk("thr_out", radio.energy_busy_threshold, ct[i]);
    end
    // Unmapped index between two live registers
    wr(30'h00000204, 8'hFF);
    ahb(30'h00000204, 1'b0, 8'h00, v);
    chk("unmapped", v, 32'h0);
    chk("hresp", hresp, 32'h0);
    ahb(IDX_BATT, 1'b0, 8'h00, v);
    chk("batt_kept", v, 32'h000000F0);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    #1;
    chk("radio_rst2", {31'h0, radio === '0}, 32'h1);
    chk("cca_rst2", cca_busy, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(IDX_CHAN, 1'b0, 8'h00, v);
    chk("chan_rst2", v, 32'h0);
    end_sim();
  end
endmodule // tb_rfcfg_regbank
